//--- bench/dual_uart_host_port_sva.sv
`timescale 1ns/1ps
module dual_uart_host_port_sva (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // host bus
  input wire logic cs_n_in,
  input wire logic read_strobe_n_in,
  input wire logic [7:0] host_data_lines_out,
  input wire logic host_data_lines_oe_n_out,
  // channel pins
  input wire logic channel_a_irq_out,
  input wire logic channel_b_irq_out,
  input wire logic channel_a_multi_out,
  input wire logic channel_b_multi_out,
  input wire logic [1:0] rx_dma_ready_n_out,
  input wire logic [1:0] tx_dma_ready_n_out
);
  // one domain, reset disables every check
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // deselected device keeps its read latch and floats the bus
  property p_cs_hold;
    cs_n_in |=> $stable(host_data_lines_out);
  endproperty
  a_cs_hold: assert property (p_cs_hold)
    else $error("read data changed while deselected");
  property p_cs_float;
    cs_n_in |=> host_data_lines_oe_n_out;
  endproperty
  a_cs_float: assert property (p_cs_float)
    else $error("bus driven while deselected");
  // read strobe drives the bus one edge later
  property p_rd_drive;
    (!cs_n_in && !read_strobe_n_in) |=> !host_data_lines_oe_n_out;
  endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("bus not driven during read");
  property p_oe_cause;
    !host_data_lines_oe_n_out |-> !$past(cs_n_in) && !$past(read_strobe_n_in);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("bus driven without a read");
  // writes never turn the bus around
  property p_wr_float;
    (!cs_n_in && read_strobe_n_in) |=> host_data_lines_oe_n_out;
  endproperty
  a_wr_float: assert property (p_wr_float)
    else $error("bus driven during write");
  property p_rd_hold;
    read_strobe_n_in |=> $stable(host_data_lines_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without read");
  // first edge after reset still shows reset levels
  property p_rst_host;
    $past(rst_in) |-> host_data_lines_oe_n_out && !channel_a_irq_out &&
      !channel_b_irq_out;
  endproperty
  a_rst_host: assert property (p_rst_host)
    else $error("bus or irq not cleared by reset");
  property p_rst_pins;
    $past(rst_in) |-> channel_a_multi_out && channel_b_multi_out &&
      tx_dma_ready_n_out == 2'b00 && rx_dma_ready_n_out == 2'b11;
  endproperty
  a_rst_pins: assert property (p_rst_pins)
    else $error("multi or ready pins not at reset level");
endmodule : dual_uart_host_port_sva

bind dual_uart_host_port dual_uart_host_port_sva i_dual_uart_host_port_sva (
  .ref_clk_in(ref_clk_in),
  .rst_in(rst_in),
  .cs_n_in(cs_n_in),
  .read_strobe_n_in(read_strobe_n_in),
  .host_data_lines_out(host_data_lines_out),
  .host_data_lines_oe_n_out(host_data_lines_oe_n_out),
  .channel_a_irq_out(channel_a_irq_out),
  .channel_b_irq_out(channel_b_irq_out),
  .channel_a_multi_out(channel_a_multi_out),
  .channel_b_multi_out(channel_b_multi_out),
  .rx_dma_ready_n_out(rx_dma_ready_n_out),
  .tx_dma_ready_n_out(tx_dma_ready_n_out)
);

//--- bench/dual_uart_host_port_test.sv
`timescale 1ns/1ps
module dual_uart_host_port_test;
  import dual_uart_pkg::*;
  // clock, reset and bus wires
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cs_n, pick, rd_n, wr_n, oe_n, irq_a, irq_b, mf_a, mf_b, oe;
  logic [2:0] sel;
  logic [7:0] wdat, rdat_q, rdat;
  logic [1:0] rx_rdy, tx_rdy, baud, tx_stb;
  logic [1:0][7:0] lctl, tx_chr;
  logic [1:0][1:0] mctl;
  int n, m;
  // framer and modem side
  logic [1:0] tx_ok = 2'b11;
  logic [1:0][7:0] rx_ch = '0;
  logic [1:0][2:0] rx_err = '0;
  logic [1:0] rx_stb = 2'b00;
  logic [1:0][3:0] modem_n = '1;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  localparam logic CH_PICK_A = ~PICK_B;

  always #5 ref_clk_in = ~ref_clk_in;

  host_cpu_model i_host_cpu_model (
    .ref_clk_in(ref_clk_in), .cs_n_out(cs_n), .channel_pick_out(pick),
    .register_select_lines_out(sel), .read_strobe_n_out(rd_n),
    .write_strobe_n_out(wr_n), .host_data_lines_out(wdat),
    .host_data_lines_in(rdat_q), .host_data_lines_oe_n_in(oe_n));

  dual_uart_host_port #(.FIFO_DEPTH(16)) i_dual_uart_host_port (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .cs_n_in(cs_n),
    .channel_pick_in(pick), .register_select_lines_in(sel),
    .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n),
    .host_data_lines_in(wdat), .host_data_lines_out(rdat_q),
    .host_data_lines_oe_n_out(oe_n), .channel_a_irq_out(irq_a),
    .channel_b_irq_out(irq_b), .channel_a_multi_out(mf_a),
    .channel_b_multi_out(mf_b), .rx_dma_ready_n_out(rx_rdy),
    .tx_dma_ready_n_out(tx_rdy), .modem_n_in(modem_n),
    .modem_ctrl_n_out(mctl), .line_ctrl_out(lctl), .baud16x_clock_out(baud),
    .tx_char_out(tx_chr), .tx_char_stb_out(tx_stb), .tx_char_ready_in(tx_ok),
    .rx_char_in(rx_ch), .rx_err_in(rx_err), .rx_char_stb_in(rx_stb));

  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic rd_chk(input logic ch, input logic [2:0] a,
                        input logic [7:0] exp, input string nm);
    i_host_cpu_model.rd(ch, a, rdat, oe);
    check(nm, rdat, exp);
    check("oe_n", {7'h0, oe}, 8'h00);
  endtask : rd_chk

  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
    i_host_cpu_model.wr(ch, a, d, 1'b0);
  endtask : wr

  // one framer character on channel b, strobe high for a single edge
  task automatic feed(input logic [7:0] c, input logic [2:0] e);
    @(posedge ref_clk_in);
    rx_ch[1] <= c;
    rx_err[1] <= e;
    rx_stb[1] <= 1'b1;
    @(posedge ref_clk_in);
    rx_stb[1] <= 1'b0;
  endtask : feed

  // settle a few edges, then look off the edge
  task automatic pause;
    repeat (3) @(posedge ref_clk_in);
    #1;
  endtask : pause

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // hang guard, tests need a few hundred cycles
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    #1;
    check("rst pins", {irq_a, irq_b, mf_a, mf_b, rx_rdy, tx_rdy},
          8'h3c);
    check("rst bus", {7'h0, oe_n}, 8'h01);
    // separate scratch per channel, refused write with select high
    wr(CH_PICK_A, REG_SPR, 8'h5a);
    wr(PICK_B, REG_SPR, 8'ha5);
    i_host_cpu_model.wr(CH_PICK_A, REG_SPR, 8'hff, 1'b1);
    rd_chk(CH_PICK_A, REG_SPR, 8'h5a, "spr a");
    rd_chk(PICK_B, REG_SPR, 8'ha5, "spr b");
    wr(CH_PICK_A, REG_LCR, 8'h03);
    rd_chk(CH_PICK_A, REG_LCR, 8'h03, "lcr a");
    // thre source with output enable bit, only channel a
    wr(CH_PICK_A, REG_IER, 8'h02);
    wr(CH_PICK_A, REG_MCR, 8'h08);
    pause();
    check("irq on", {5'h0, irq_b, irq_a, mf_a}, 8'h02);
    wr(CH_PICK_A, REG_MCR, 8'h00);
    pause();
    check("irq off", {5'h0, irq_b, irq_a, mf_a}, 8'h01);
    // loop-back on a, eight bit characters
    wr(CH_PICK_A, REG_MCR, 8'h10);
    wr(CH_PICK_A, REG_DATA, 8'h55);
    pause();
    check("rx rdy a", {7'h0, rx_rdy[0]}, 8'h00);
    rd_chk(CH_PICK_A, REG_DATA, 8'h55, "loop a");
    pause();
    check("rx rdy a", {7'h0, rx_rdy[0]}, 8'h01);
    // framer char on b, five bit reset length masks the top
    feed(8'h81, 3'b000);
    pause();
    check("rx rdy b", {6'h0, rx_rdy}, 8'h01);
    rd_chk(PICK_B, REG_DATA, 8'h01, "rx b");
    // dual write plus rx-ready multi function on a
    wr(CH_PICK_A, REG_LCR, LCR_AFR_KEY);
    wr(CH_PICK_A, REG_ISR, 8'h05);
    wr(CH_PICK_A, REG_LCR, 8'h03);
    wr(PICK_B, REG_SPR, 8'h77);
    wr(CH_PICK_A, REG_SPR, 8'h3c);
    rd_chk(PICK_B, REG_SPR, 8'h3c, "dual b");
    wr(PICK_B, REG_SPR, 8'h66);
    rd_chk(CH_PICK_A, REG_SPR, 8'h3c, "spr a");
    rd_chk(PICK_B, REG_SPR, 8'h66, "spr b");
    check("mf a idle", {7'h0, mf_a}, 8'h01);
    wr(CH_PICK_A, REG_DATA, 8'hc3);
    pause();
    check("mf a rdy", {7'h0, mf_a}, 8'h00);
    check("tx b", tx_chr[1], 8'hc3);
    check("lcr b", lctl[1], 8'h03);
    rd_chk(CH_PICK_A, REG_DATA, 8'hc3, "loop a");
    // modem outputs: b follows its bits, a forced idle in loop-back
    wr(PICK_B, REG_MCR, 8'h01);
    pause();
    check("mctl", {4'h0, mctl[1], mctl[0]}, 8'h0b);
    // fifo and dma mode on b, trigger four, framer stalled until full
    wr(PICK_B, REG_ISR, 8'h49);
    tx_ok[1] <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      wr(PICK_B, REG_DATA, 8'(i));
      if (i == 14) begin
        pause();
        check("tx rdy 15", {7'h0, tx_rdy[1]}, 8'h00);
      end
    end
    pause();
    check("tx rdy 16", {7'h0, tx_rdy[1]}, 8'h01);
    @(posedge ref_clk_in);
    tx_ok[1] <= 1'b1;
    n = 0;
    repeat (24) begin
      @(posedge ref_clk_in);
      #1;
      n += int'(tx_stb[1]);
    end
    check("tx stb b", 8'(n), 8'h10);
    check("tx last b", tx_chr[1], 8'h0f);
    check("tx rdy free", {7'h0, tx_rdy[1]}, 8'h00);
    // receive trigger paces dma ready, error flags ride with the char
    feed(8'h30, 3'b010);
    feed(8'h31, 3'b000);
    feed(8'h32, 3'b000);
    pause();
    check("rx rdy 3", {7'h0, rx_rdy[1]}, 8'h01);
    feed(8'h33, 3'b000);
    pause();
    check("rx rdy 4", {7'h0, rx_rdy[1]}, 8'h00);
    rd_chk(PICK_B, REG_LSR, 8'he9, "lsr b");
    rd_chk(PICK_B, REG_DATA, 8'h30, "fifo b");
    pause();
    check("rx rdy pop", {7'h0, rx_rdy[1]}, 8'h01);
    // divisor four on b, a keeps zero and stays still
    wr(PICK_B, REG_LCR, 8'h83);
    wr(PICK_B, REG_DATA, 8'h04);
    wr(PICK_B, REG_LCR, 8'h03);
    pause();
    n = 0;
    m = 0;
    repeat (40) begin
      @(posedge ref_clk_in);
      #1;
      n += int'(baud[1]);
      m += int'(baud[0]);
    end
    check("baud b", 8'(n), 8'h0a);
    check("baud a", 8'(m), 8'h00);
    give_verdict();
  end
endmodule : dual_uart_host_port_test

//--- bench/host_cpu_model.sv
`timescale 1ns/1ps
module host_cpu_model (
  // clock
  input wire logic ref_clk_in,
  // bus toward the device
  output logic cs_n_out,
  output logic channel_pick_out,
  output logic [2:0] register_select_lines_out,
  output logic read_strobe_n_out,
  output logic write_strobe_n_out,
  output logic [7:0] host_data_lines_out,
  // read path from the device
  input wire logic [7:0] host_data_lines_in,
  input wire logic host_data_lines_oe_n_in
);
  // idle bus: deselected, strobes high
  initial begin
    cs_n_out = 1'b1;
    channel_pick_out = 1'b0;
    register_select_lines_out = 3'h0;
    read_strobe_n_out = 1'b1;
    write_strobe_n_out = 1'b1;
    host_data_lines_out = 8'h00;
  end
  // off set means the select stays high, a refused cycle
  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d,
                    input logic off);
    @(posedge ref_clk_in);
    cs_n_out <= off;
    channel_pick_out <= ch;
    register_select_lines_out <= a;
    host_data_lines_out <= d;
    write_strobe_n_out <= 1'b0;
    @(posedge ref_clk_in);
    cs_n_out <= 1'b1;
    write_strobe_n_out <= 1'b1;
    host_data_lines_out <= ~d; // released lines must not look valid
  endtask : wr
  // strobe held one extra edge so the answer is taken settled
  task automatic rd(input logic ch, input logic [2:0] a, output logic [7:0] d,
                    output logic oe_n);
    @(posedge ref_clk_in);
    cs_n_out <= 1'b0;
    channel_pick_out <= ch;
    register_select_lines_out <= a;
    read_strobe_n_out <= 1'b0;
    @(posedge ref_clk_in);
    #1;
    d = host_data_lines_in;
    oe_n = host_data_lines_oe_n_in;
    @(posedge ref_clk_in);
    cs_n_out <= 1'b1;
    read_strobe_n_out <= 1'b1;
  endtask : rd
endmodule : host_cpu_model

//--- rtl/char_fifo.sv
`timescale 1ns/1ps
module char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int CNT_W = 5
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // control
  input wire logic flush_in,
  input wire logic push_in,
  input wire logic pop_in,
  // data
  input wire logic [WIDTH-1:0] data_in,
  output logic [WIDTH-1:0] head_out,
  output logic [CNT_W-1:0] count_out
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

  // a one-entry buffer would need zero-width pointers
  if (DEPTH < 2 || CNT_W < $clog2(DEPTH + 1)) begin : g_param_check
    $error("char_fifo DEPTH or CNT_W out of range");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  wire do_push = push_in && (count_q != CNT_W'(DEPTH));
  wire do_pop = pop_in && (count_q != '0);

  assign head_out = mem_q[rd_ptr_q];
  assign count_out = count_q;

  // storage needs no reset, only pointers carry meaning
  always_ff @(posedge ref_clk_in) begin
    if (do_push) begin
      mem_q[wr_ptr_q] <= data_in;
    end
  end

  // pointers wrap by compare so depth need not be a power of two
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else if (flush_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= (wr_ptr_q == LAST) ? '0 : wr_ptr_q + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST) ? '0 : rd_ptr_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_q <= count_q + 1'b1;
      end else if (do_pop && !do_push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : char_fifo

//--- rtl/dual_uart_host_port.sv
`timescale 1ns/1ps
// Summary of operation
// - register-select lines pick the register accessed
// - channel pick low means B, high A
// - device select high: strobes ignored, bus undriven
// - dual-write bit sends writes to both channels
// - data bit zero is least significant, sent first
// - irq needs irq-enable bit, enable, pending
// - line error, rx data, tx empty, modem change
// - read strobe fall drives addressed register out
// - write strobe stores bus byte in register
// - alternate function bits 1-2 pick multi output
// - sixteen byte fifos, rx keeps error flags
// - four rx trigger levels, fixed tx level
// - five to eight bits, even/odd/no parity
// - fifo-less single buffer model after reset
// - dma paced by trigger through ready outputs
// - loop-back routes transmit into own receiver
// - each channel has own baud divider
// - irq-enable indication high when disabled, default high
// - rx ready low when data or trigger reached
// - tx ready low while a location is free
// - reset clears registers, serial paths disabled
module dual_uart_host_port
  import dual_uart_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // host bus
  input wire logic cs_n_in,
  input wire logic channel_pick_in,
  input wire logic [2:0] register_select_lines_in,
  input wire logic read_strobe_n_in,
  input wire logic write_strobe_n_in,
  input wire logic [7:0] host_data_lines_in,
  output logic [7:0] host_data_lines_out,
  output logic host_data_lines_oe_n_out,
  // per-channel pins, index 0 is channel A
  output logic channel_a_irq_out,
  output logic channel_b_irq_out,
  output logic channel_a_multi_out,
  output logic channel_b_multi_out,
  output logic [1:0] rx_dma_ready_n_out,
  output logic [1:0] tx_dma_ready_n_out,
  // modem lines, active low: {cd, ri, dsr, cts} and {rts, dtr}
  input wire logic [1:0][3:0] modem_n_in,
  output logic [1:0][1:0] modem_ctrl_n_out,
  // character stream to and from the serial framers
  output logic [1:0][7:0] line_ctrl_out,
  output logic [1:0] baud16x_clock_out,
  output logic [1:0][7:0] tx_char_out,
  output logic [1:0] tx_char_stb_out,
  input wire logic [1:0] tx_char_ready_in,
  input wire logic [1:0][7:0] rx_char_in,
  input wire logic [1:0][2:0] rx_err_in,
  input wire logic [1:0] rx_char_stb_in
);
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

  if (FIFO_DEPTH < 14 || FIFO_DEPTH > 255) begin : g_depth_check
    $error("FIFO_DEPTH must lie between 14 and 255");
  end

  // receive trigger level in characters
  function automatic logic [CNT_W-1:0] trig_level(input logic [1:0] sel);
    logic [7:0] lvl;
    unique case (sel)
      2'd0: lvl = RX_TRIG_0;
      2'd1: lvl = RX_TRIG_1;
      2'd2: lvl = RX_TRIG_2;
      2'd3: lvl = RX_TRIG_3;
    endcase
    return lvl[CNT_W-1:0];
  endfunction : trig_level

  // keep only the bits of the programmed character length
  function automatic logic [7:0] char_mask(input logic [1:0] wlen);
    return 8'hff >> (2'd3 - wlen);
  endfunction : char_mask

  // strobe edge detection on the synchronous bus inputs
  logic rd_prev_q;
  logic wr_prev_q;
  logic [7:0] data_out_q;
  logic oe_n_q;
  logic [1:0][7:0] rdata_w;
  logic [1:0] dual_w;
  logic [1:0] irq_w;
  logic [1:0] multi_w;

  wire cs_act = !cs_n_in;
  wire rd_fall = cs_act && !read_strobe_n_in && rd_prev_q;
  wire wr_fall = cs_act && !write_strobe_n_in && wr_prev_q;
  wire sel_idx = (channel_pick_in == PICK_B) ? 1'b1 : 1'b0;
  wire dual_on = dual_w[sel_idx];

  // read data is latched at the strobe's falling edge
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
      data_out_q <= 8'h00;
      oe_n_q <= 1'b1;
    end else begin
      rd_prev_q <= read_strobe_n_in;
      wr_prev_q <= write_strobe_n_in;
      oe_n_q <= !(cs_act && !read_strobe_n_in);
      if (rd_fall) begin
        data_out_q <= rdata_w[sel_idx];
      end
    end
  end

  assign host_data_lines_out = data_out_q;
  assign host_data_lines_oe_n_out = oe_n_q;
  assign channel_a_irq_out = irq_w[CH_A];
  assign channel_b_irq_out = irq_w[CH_B];
  assign channel_a_multi_out = multi_w[CH_A];
  assign channel_b_multi_out = multi_w[CH_B];

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    // one complete register set per channel
    logic [3:0] ier_q;
    logic [7:0] lcr_q;
    logic [4:0] mcr_q;
    logic [7:0] spr_q;
    logic [7:0] dll_q;
    logic [7:0] dlm_q;
    logic [2:0] afr_q;
    logic fifo_en_q;
    logic dma_q;
    logic [1:0] trig_q;
    logic ovr_q;
    logic thre_q;
    logic [3:0] mstat_q;
    logic [3:0] mdelta_q;
    logic [15:0] baud_cnt_q;
    logic baud_q;
    logic irq_q;
    logic multi_q;
    logic rx_rdy_n_q;
    logic tx_rdy_n_q;
    logic [1:0] mctl_n_q;
    logic [7:0] tx_char_q;
    logic tx_stb_q;
    logic [10:0] rx_head;
    logic [7:0] tx_head;
    logic [CNT_W-1:0] rx_cnt;
    logic [CNT_W-1:0] tx_cnt;
    logic [7:0] rd_mux;
    logic [3:0] code;

    // access decode for this channel
    wire wr = wr_fall && (dual_on || (sel_idx == 1'(ch)));
    wire rd = rd_fall && (sel_idx == 1'(ch));
    wire [2:0] adr = register_select_lines_in;
    wire dlab = lcr_q[LCR_DLAB];
    wire afr_acc = (lcr_q == LCR_AFR_KEY);
    wire loop = mcr_q[MCR_LOOP];
    wire [7:0] wd = host_data_lines_in;

    // single buffer until fifos are switched on
    wire [CNT_W-1:0] cap = fifo_en_q ? CNT_W'(FIFO_DEPTH) : CNT_W'(1);
    wire rx_full = (rx_cnt >= cap);
    wire tx_full = (tx_cnt >= cap);
    wire dr = (rx_cnt != '0);
    wire [CNT_W-1:0] trig = trig_level(trig_q);
    wire rx_trig_hit = fifo_en_q ? (rx_cnt >= trig) : dr;

    // register writes and their side effects
    wire wr_thr = wr && adr == REG_DATA && !dlab;
    wire wr_fcr = wr && adr == REG_ISR && !afr_acc;
    wire fcr_chg = wr_fcr && (wd[FCR_EN] != fifo_en_q);
    wire rx_flush = wr_fcr && (wd[FCR_RX_RST] || fcr_chg);
    wire tx_flush = wr_fcr && (wd[FCR_TX_RST] || fcr_chg);

    // read side effects
    wire rd_rhr = rd && adr == REG_DATA && !dlab;
    wire rd_isr = rd && adr == REG_ISR && !afr_acc;
    wire rd_lsr = rd && adr == REG_LSR;
    wire rd_msr = rd && adr == REG_MSR;

    // transmit drains to the framer, or to our own receiver in loop-back
    wire tx_pop = (tx_cnt != '0) &&
                  (loop ? !rx_full : tx_char_ready_in[ch]);
    wire rx_ext = rx_char_stb_in[ch] && !loop;
    wire rx_push = loop ? tx_pop : (rx_ext && !rx_full);
    wire [10:0] rx_word = loop ? {3'b000, tx_head} :
                          {rx_err_in[ch], rx_char_in[ch]};

    // sixteen-deep buffers, error flags stored with each character
    char_fifo #(.WIDTH(11), .DEPTH(FIFO_DEPTH), .CNT_W(CNT_W)) u_rx (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .flush_in(rx_flush),
      .push_in(rx_push),
      .pop_in(rd_rhr),
      .data_in(rx_word),
      .head_out(rx_head),
      .count_out(rx_cnt)
    );
    char_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .CNT_W(CNT_W)) u_tx (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .flush_in(tx_flush),
      .push_in(wr_thr && !tx_full),
      .pop_in(tx_pop),
      .data_in(wd),
      .head_out(tx_head),
      .count_out(tx_cnt)
    );

    // line and modem status
    wire [2:0] head_err = dr ? rx_head[10:8] : 3'b000;
    wire tx_empty = (tx_cnt == '0);
    wire [7:0] lsr = {fifo_en_q && |head_err, tx_empty, tx_empty,
                      head_err, ovr_q, dr};
    wire [3:0] mnow = loop ? {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]} :
                      ~modem_n_in[ch];
    wire [3:0] mchg = {mnow[3] ^ mstat_q[3], mstat_q[2] & !mnow[2],
                       mnow[1:0] ^ mstat_q[1:0]};
    wire [7:0] msr = {mstat_q, mdelta_q};

    // interrupt sources in priority order
    wire src_line = ier_q[2] && (ovr_q || |head_err);
    wire src_rx = ier_q[0] && rx_trig_hit;
    wire src_thre = ier_q[1] && thre_q;
    wire src_modem = ier_q[3] && |mdelta_q;
    assign code = src_line ? ISR_LINE : src_rx ? ISR_RX :
                  src_thre ? ISR_THRE : src_modem ? ISR_MODEM : ISR_NONE;
    wire [7:0] isr = {fifo_en_q, fifo_en_q, 2'b00, code};

    // read data selection by register select
    always_comb begin
      unique case (adr)
        REG_DATA: rd_mux = dlab ? dll_q : rx_head[7:0] & char_mask(lcr_q[1:0]);
        REG_IER: rd_mux = dlab ? dlm_q : {4'h0, ier_q};
        REG_ISR: rd_mux = afr_acc ? {5'h00, afr_q} : isr;
        REG_LCR: rd_mux = lcr_q;
        REG_MCR: rd_mux = {3'b000, mcr_q};
        REG_LSR: rd_mux = lsr;
        REG_MSR: rd_mux = msr;
        REG_SPR: rd_mux = spr_q;
      endcase
    end
    assign rdata_w[ch] = rd_mux;
    assign dual_w[ch] = afr_q[AFR_DUAL];

    // control registers
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
        ier_q <= IER_RST;
        lcr_q <= LCR_RST;
        mcr_q <= MCR_RST;
        spr_q <= 8'h00;
        dll_q <= DIV_RST;
        dlm_q <= DIV_RST;
        afr_q <= AFR_RST;
        fifo_en_q <= 1'b0;
        dma_q <= 1'b0;
        trig_q <= 2'b00;
      end else if (wr) begin
        unique case (adr)
          REG_DATA: if (dlab) dll_q <= wd;
          REG_IER: if (dlab) dlm_q <= wd; else ier_q <= wd[3:0];
          REG_ISR: begin
            if (afr_acc) begin
              afr_q <= wd[2:0];
            end else begin
              fifo_en_q <= wd[FCR_EN];
              dma_q <= wd[FCR_DMA];
              trig_q <= wd[FCR_TRIG_LO +: 2];
            end
          end
          REG_LCR: lcr_q <= wd;
          REG_MCR: mcr_q <= wd[4:0];
          REG_SPR: spr_q <= wd;
          default: ;
        endcase
      end
    end

    // sticky status flags; a new event beats a same-cycle clear
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
        ovr_q <= 1'b0;
        thre_q <= 1'b1;
        mstat_q <= 4'h0;
        mdelta_q <= 4'h0;
      end else begin
        ovr_q <= (rx_ext && rx_full) || (ovr_q && !rd_lsr);
        thre_q <= (tx_pop && tx_cnt == CNT_W'(1)) ||
                  (thre_q && !wr_thr && !(rd_isr && code == ISR_THRE));
        mstat_q <= mnow;
        mdelta_q <= mchg | (mdelta_q & {4{!rd_msr}});
      end
    end

    // baud divider, zero divisor holds the generator still
    wire [15:0] div = {dlm_q, dll_q};
    wire baud_wrap = (div != 16'h0000) && (baud_cnt_q >= div - 16'h0001);

    // pin outputs, each from its own flop
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
        baud_cnt_q <= 16'h0000;
        baud_q <= 1'b0;
        irq_q <= 1'b0;
        multi_q <= 1'b1;
        rx_rdy_n_q <= 1'b1;
        tx_rdy_n_q <= 1'b0;
        mctl_n_q <= 2'b11;
        tx_char_q <= 8'h00;
        tx_stb_q <= 1'b0;
      end else begin
        baud_cnt_q <= baud_wrap ? 16'h0000 : baud_cnt_q + 16'h0001;
        baud_q <= baud_wrap;
        irq_q <= mcr_q[MCR_IRQ_EN] && (code != ISR_NONE);
        unique case (afr_q[AFR_SEL_LO +: 2])
          MF_BAUD: multi_q <= baud_wrap;
          MF_RX_RDY: multi_q <= !dr;
          default: multi_q <= !mcr_q[MCR_IRQ_EN];
        endcase
        rx_rdy_n_q <= !((fifo_en_q && dma_q) ? rx_trig_hit : dr);
        tx_rdy_n_q <= tx_full;
        mctl_n_q <= loop ? 2'b11 : ~mcr_q[1:0];
        tx_stb_q <= tx_pop && !loop;
        if (tx_pop) begin
          tx_char_q <= tx_head;
        end
      end
    end

    assign irq_w[ch] = irq_q;
    assign multi_w[ch] = multi_q;
    assign rx_dma_ready_n_out[ch] = rx_rdy_n_q;
    assign tx_dma_ready_n_out[ch] = tx_rdy_n_q;
    assign modem_ctrl_n_out[ch] = mctl_n_q;
    assign line_ctrl_out[ch] = lcr_q;
    assign baud16x_clock_out[ch] = baud_q;
    assign tx_char_out[ch] = tx_char_q;
    assign tx_char_stb_out[ch] = tx_stb_q;
  end
endmodule : dual_uart_host_port

//--- rtl/dual_uart_pkg.sv
package dual_uart_pkg;
  // register select offsets
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_IER = 3'h1;
  localparam logic [2:0] REG_ISR = 3'h2;
  localparam logic [2:0] REG_LCR = 3'h3;
  localparam logic [2:0] REG_MCR = 3'h4;
  localparam logic [2:0] REG_LSR = 3'h5;
  localparam logic [2:0] REG_MSR = 3'h6;
  localparam logic [2:0] REG_SPR = 3'h7;
  // line control value that opens the alternate function register
  localparam logic [7:0] LCR_AFR_KEY = 8'hbf;
  // field positions
  localparam int LCR_DLAB = 7;
  localparam int MCR_IRQ_EN = 3;
  localparam int MCR_LOOP = 4;
  localparam int AFR_DUAL = 0;
  localparam int AFR_SEL_LO = 1;
  localparam int FCR_EN = 0;
  localparam int FCR_RX_RST = 1;
  localparam int FCR_TX_RST = 2;
  localparam int FCR_DMA = 3;
  localparam int FCR_TRIG_LO = 6;
  // channel pick levels and channel indices
  localparam logic PICK_B = 1'b0;
  localparam int CH_A = 0;
  localparam int CH_B = 1;
  // multi-function output selection
  localparam logic [1:0] MF_IRQ_EN = 2'b00;
  localparam logic [1:0] MF_BAUD = 2'b01;
  localparam logic [1:0] MF_RX_RDY = 2'b10;
  // receive trigger levels, in characters
  localparam logic [7:0] RX_TRIG_0 = 8'h01;
  localparam logic [7:0] RX_TRIG_1 = 8'h04;
  localparam logic [7:0] RX_TRIG_2 = 8'h08;
  localparam logic [7:0] RX_TRIG_3 = 8'h0e;
  // interrupt source codes, highest priority first
  localparam logic [3:0] ISR_LINE = 4'h6;
  localparam logic [3:0] ISR_RX = 4'h4;
  localparam logic [3:0] ISR_THRE = 4'h2;
  localparam logic [3:0] ISR_MODEM = 4'h0;
  localparam logic [3:0] ISR_NONE = 4'h1;
  // reset values
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [4:0] MCR_RST = 5'h00;
  localparam logic [3:0] IER_RST = 4'h0;
  localparam logic [2:0] AFR_RST = 3'h0;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam int FIFO_DEPTH_DEF = 16;
endpackage : dual_uart_pkg
